//--- bench/gfx_master_model.sv
// Graphics controller model acting as bus master on the expansion port
`timescale 1ns/1ps
`default_nettype none
module gfx_master_model
  import gport_pkg::*;
(
  input wire logic core_clk,
  input wire logic link_clk,
  input wire logic port_bus_grant_n,
  input wire logic port_target_select_n,
  output logic port_bus_request_n,
  output logic port_frame_n,
  output logic pipelined_request_strobe_n,
  output logic [AD_W-1:0] port_addr_data_lanes_in,
  output logic [CBE_W-1:0] port_cmd_byte_enable_in,
  output logic port_parity_in,
  output logic dbi_lo_in,
  output logic upper_first_data_strobe,
  output logic upper_second_data_strobe,
  output logic link_run
);
  int n;
  initial
  begin
    {port_bus_request_n, port_frame_n, pipelined_request_strobe_n} = 3'h7;
    port_addr_data_lanes_in = 32'h0000_0000;
    port_cmd_byte_enable_in = 4'hF;
    port_parity_in = 1'b1;
    {dbi_lo_in, upper_first_data_strobe, upper_second_data_strobe} = 3'h0;
    link_run = 1'b1;
    repeat (10) @(negedge core_clk);
    link_run = 1'b0;
  end
  // Released lanes show the inverse of their last value
  task automatic release_lanes();
    port_addr_data_lanes_in = ~port_addr_data_lanes_in;
    port_cmd_byte_enable_in = ~port_cmd_byte_enable_in;
    port_parity_in = 1'b1;
  endtask
  task automatic get_grant();
    port_bus_request_n = 1'b0;
    for (n = 0; n < 16 && port_bus_grant_n !== 1'b0; n++) @(negedge core_clk);
  endtask
  task automatic frame_start(input logic [31:0] addr, input logic [3:0] cmd, input logic bad);
    get_grant();
    @(negedge core_clk);
    port_frame_n = 1'b0;
    port_addr_data_lanes_in = addr;
    port_cmd_byte_enable_in = cmd;
    port_parity_in = (^{addr, cmd}) ^ bad;
    for (n = 0; n < 16 && port_target_select_n !== 1'b0; n++) @(negedge core_clk);
    port_bus_request_n = 1'b1;
  endtask
  task automatic frame_end();
    @(negedge core_clk);
    port_frame_n = 1'b1;
    release_lanes();
    for (n = 0; n < 16 && port_target_select_n !== 1'b1; n++) @(negedge core_clk);
  endtask
  task automatic pipe_request(input logic [31:0] addr, input logic [3:0] cmd);
    get_grant();
    @(negedge core_clk);
    pipelined_request_strobe_n = 1'b0;
    port_addr_data_lanes_in = addr;
    port_cmd_byte_enable_in = cmd;
    for (n = 0; n < 16 && port_bus_grant_n !== 1'b1; n++) @(negedge core_clk);
    @(negedge core_clk);
    {pipelined_request_strobe_n, port_bus_request_n} = 2'h3;
    release_lanes();
  endtask
  // Two items: odd on first strobe, even on second
  task automatic dbi_items(input logic [15:0] w1, input logic [15:0] w2, input logic i1, input logic i2);
    link_run = 1'b1;
    repeat (3) @(negedge link_clk);
    port_addr_data_lanes_in[15:0] = i1 ? ~w1 : w1;
    dbi_lo_in = i1;
    @(negedge link_clk);
    upper_first_data_strobe = 1'b1;
    @(negedge link_clk);
    port_addr_data_lanes_in[15:0] = i2 ? ~w2 : w2;
    dbi_lo_in = i2;
    upper_first_data_strobe = 1'b0;
    repeat (8) @(negedge link_clk);
    upper_second_data_strobe = 1'b1;
    @(negedge link_clk);
    upper_second_data_strobe = 1'b0;
    dbi_lo_in = ~dbi_lo_in;
    release_lanes();
    repeat (2) @(negedge link_clk);
    link_run = 1'b0;
  endtask
endmodule // gfx_master_model
`default_nettype wire

//--- bench/graphics_port_bus_signals_bench.sv
// Self-checking bench for the graphics port target
`timescale 1ns/1ps
`default_nettype none
module graphics_port_bus_signals_bench;
  import gport_pkg::*;
  typedef struct packed
  {
    logic [1:0] kind;
    logic [2:0] purpose;
    logic [1:0] rate;
    logic [31:0] addr;
    logic [3:0] cmd;
  } row_t;
  logic core_clk = 1'b0, link_clk = 1'b0, resetn = 1'b0, mode_30 = 1'b1, queued_data_ready = 1'b0;
  logic [1:0] channel_rate = 2'h0;
  logic [2:0] queued_data_purpose = 3'h0;
  logic [31:0] read_data = 32'hC0DE_5A17;
  logic req_n, frame_n, pipe_n, par, dbi, stf, sts, link_run, grant_n, sel_n, sel_oe_n, ad_oe_n, par_out;
  logic par_oe_n, par_err, taken;
  logic [31:0] ad, ad_out, cap_addr;
  logic [3:0] cbe, cap_cmd, cap_be;
  logic [2:0] gst;
  logic [15:0] lo_word;
  logic [1:0] act_rate;
  int errors = 0, comparisons = 0, cycles = 0, n;
  row_t rows [8] = '{'{0, GST_LP_READ, RATE_1X, 0, 0}, '{0, GST_LP_WRITE, RATE_2X, 0, 0},
    '{0, GST_HP_READ, RATE_4X, 0, 0}, '{0, GST_HP_WRITE, RATE_8X, 0, 0}, '{0, GST_FAST_WRITE, RATE_4X, 0, 0},
    '{1, GST_START_REQ, RATE_8X, 32'h8000_0004, CMD_READ}, '{1, GST_START_REQ, RATE_4X, 32'h0FFF_FFFC, CMD_WRITE},
    '{2, GST_START_REQ, RATE_8X, 32'h1234_5678, 4'hA}};
  always #50 core_clk = ~core_clk;
  always
  begin
    #16;
    if (link_run) link_clk = ~link_clk;
  end
  gport_target u_dut (.core_clk(core_clk), .resetn(resetn), .link_clk(link_clk), .mode_30(mode_30),
    .channel_rate(channel_rate), .port_bus_request_n(req_n), .port_frame_n(frame_n),
    .pipelined_request_strobe_n(pipe_n), .port_addr_data_lanes_in(ad), .port_cmd_byte_enable_in(cbe),
    .port_parity_in(par), .dbi_lo_in(dbi), .upper_first_data_strobe(stf), .upper_second_data_strobe(sts),
    .queued_data_ready(queued_data_ready), .queued_data_purpose(queued_data_purpose), .read_data(read_data),
    .port_bus_grant_n(grant_n), .grant_purpose_status(gst), .port_target_select_n(sel_n),
    .port_target_select_oe_n(sel_oe_n), .port_addr_data_lanes_out(ad_out), .port_addr_data_lanes_oe_n(ad_oe_n),
    .port_parity_out(par_out), .port_parity_oe_n(par_oe_n), .parity_error(par_err), .captured_addr(cap_addr),
    .captured_cmd(cap_cmd), .captured_be(cap_be), .lo_half_word(lo_word), .active_rate(act_rate),
    .queued_data_taken(taken));
  gfx_master_model u_agent (.core_clk(core_clk), .link_clk(link_clk), .port_bus_grant_n(grant_n),
    .port_target_select_n(sel_n), .port_bus_request_n(req_n), .port_frame_n(frame_n),
    .pipelined_request_strobe_n(pipe_n), .port_addr_data_lanes_in(ad), .port_cmd_byte_enable_in(cbe),
    .port_parity_in(par), .dbi_lo_in(dbi), .upper_first_data_strobe(stf), .upper_second_data_strobe(sts),
    .link_run(link_run));
  // ---------------------------------------------------------------
  // Compare and closing
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      stop_test();
    end
  end
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (8) @(negedge core_clk);
    check("grant_n", 1, grant_n);
    check("status", GST_RST, gst);
    check("select", 3'h7, {sel_n, sel_oe_n, ad_oe_n});
    check("parity", 2'h3, {par_out, par_oe_n});
    resetn = 1'b1;
    repeat (3) @(negedge core_clk);
    $display("test reset done");
    foreach (rows[i])
    begin
      channel_rate = rows[i].rate;
      if (rows[i].kind == 0)
      begin
        queued_data_purpose = rows[i].purpose;
        queued_data_ready = 1'b1;
        for (n = 0; n < 16 && grant_n !== 1'b0; n++) @(negedge core_clk);
        check("status", rows[i].purpose, gst);
        check("taken", 1, taken);
        queued_data_ready = 1'b0;
        @(negedge core_clk);
        check("grant_n", 1, grant_n);
        check("rate", rows[i].rate, act_rate);
        check("lanes_oe_n", rows[i].purpose != GST_LP_READ && rows[i].purpose != GST_HP_READ, ad_oe_n);
        if (rows[i].purpose == GST_LP_READ || rows[i].purpose == GST_HP_READ)
          check("read_data", read_data, ad_out);
      end
      else if (rows[i].kind == 1)
      begin
        u_agent.frame_start(rows[i].addr, rows[i].cmd, 1'b0);
        repeat (2) @(negedge core_clk);
        check("status", rows[i].purpose, gst);
        check("select", 2'h0, {sel_n, sel_oe_n});
        check("addr", rows[i].addr, cap_addr);
        check("cmd", rows[i].cmd, cap_cmd);
        check("rate", RATE_1X, act_rate);
        check("parity_err", 0, par_err);
        check("parity_oe_n", 1, par_oe_n);
        check("be", rows[i].cmd, cap_be);
        u_agent.frame_end();
        check("select_n", 1, sel_n);
      end
      else
      begin
        u_agent.pipe_request(rows[i].addr, rows[i].cmd);
        check("select_n", 1, sel_n);
        check("addr", rows[i].addr, cap_addr);
        check("cmd", rows[i].cmd, cap_cmd);
      end
      repeat (6) @(negedge core_clk);
      $display("test row %0d done", i);
    end
    u_agent.frame_start(32'h0000_0001, CMD_WRITE, 1'b1);
    repeat (2) @(negedge core_clk);
    check("parity_err", 1, par_err);
    u_agent.frame_end();
    $display("test bad parity done");
    u_agent.dbi_items(16'h1234, 16'hA5C3, 1'b0, 1'b1);
    repeat (8) @(negedge core_clk);
    check("lo_word", 16'hA5C3, lo_word);
    mode_30 = 1'b0;
    repeat (4) @(negedge core_clk);
    u_agent.dbi_items(16'h0F0F, 16'h5555, 1'b1, 1'b1);
    repeat (8) @(negedge core_clk);
    check("lo_word", 16'hA5C3, lo_word);
    $display("test inversion done");
    stop_test();
  end
endmodule // graphics_port_bus_signals_bench
`default_nettype wire

//--- hdl/dbi_capture.sv
// Link-side capture of low-half lanes with bus inversion
`timescale 1ns/1ps
`default_nettype none
module dbi_capture
  import gport_pkg::*;
(
  input wire logic strobe_clk,
  input wire logic link_rst_n,
  input wire logic mode_30,
  input wire logic upper_first_data_strobe,
  input wire logic upper_second_data_strobe,
  input wire logic [LO_HALF_W-1:0] lo_lanes,
  input wire logic dbi_lo,
  output logic [LO_HALF_W-1:0] word_reg,
  output logic word_toggle_reg
);

  logic first_d_reg;
  logic second_d_reg;
  wire first_rise = upper_first_data_strobe & ~first_d_reg;
  wire second_rise = upper_second_data_strobe & ~second_d_reg;
  wire item_edge = first_rise | second_rise;
  wire invert_now = mode_30 & dbi_lo;
  wire [LO_HALF_W-1:0] word_next = invert_now ? ~lo_lanes : lo_lanes;

  always_ff @(posedge strobe_clk)
  begin
    if (!link_rst_n)
    begin
      first_d_reg <= 1'b0;
      second_d_reg <= 1'b0;
      word_reg <= '0;
      word_toggle_reg <= 1'b0;
    end
    else
    begin
      first_d_reg <= upper_first_data_strobe;
      second_d_reg <= upper_second_data_strobe;
      if (item_edge)
      begin
        word_reg <= word_next;
        word_toggle_reg <= ~word_toggle_reg;
      end
    end
  end

  chk_dbi_invert: assert property (@(posedge strobe_clk) disable iff (!link_rst_n)
    item_edge && mode_30 && dbi_lo |=> word_reg == ~$past(lo_lanes))
    else $error("low half not inverted");
  chk_dbi_mode20: assert property (@(posedge strobe_clk) disable iff (!link_rst_n)
    item_edge && !mode_30 |=> word_reg == $past(lo_lanes))
    else $error("inversion applied outside 3.0 mode");
  chk_dbi_strobe: assert property (@(posedge strobe_clk) disable iff (!link_rst_n)
    !item_edge |=> $stable(word_toggle_reg))
    else $error("capture without upper strobe edge");

endmodule // dbi_capture
`default_nettype wire

//--- hdl/gport_pkg.sv
// Constants and types for the graphics expansion port target
package gport_pkg;

  // ---------------------------------------------------------------
  // Lane widths
  // ---------------------------------------------------------------
  localparam int AD_W = 32;
  localparam int CBE_W = 4;
  localparam int GST_W = 3;
  localparam int LO_HALF_W = 16;

  // ---------------------------------------------------------------
  // Grant purpose encodings
  // ---------------------------------------------------------------
  localparam logic [2:0] GST_LP_READ = 3'h0;
  localparam logic [2:0] GST_LP_WRITE = 3'h1;
  localparam logic [2:0] GST_HP_READ = 3'h2;
  localparam logic [2:0] GST_HP_WRITE = 3'h3;
  localparam logic [2:0] GST_FAST_WRITE = 3'h4;
  localparam logic [2:0] GST_START_REQ = 3'h7;

  // ---------------------------------------------------------------
  // Data rates
  // ---------------------------------------------------------------
  localparam logic [1:0] RATE_1X = 2'h0;
  localparam logic [1:0] RATE_2X = 2'h1;
  localparam logic [1:0] RATE_4X = 2'h2;
  localparam logic [1:0] RATE_8X = 2'h3;

  // ---------------------------------------------------------------
  // Bus commands seen in the address phase
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_READ = 4'h0;
  localparam logic [3:0] CMD_WRITE = 4'h1;

  // ---------------------------------------------------------------
  // Reset values and timing counts
  // ---------------------------------------------------------------
  localparam logic [AD_W-1:0] AD_RST = 32'h0000_0000;
  localparam logic [2:0] GST_RST = 3'h7;
  localparam int GRANT_HOLD_CYC = 1;
  localparam int DATA_BEATS = 4;

  // ---------------------------------------------------------------
  // Core port state
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_GRANT = 5'b00010,
    ST_FRAME = 5'b00100,
    ST_PIPE = 5'b01000,
    ST_DATA = 5'b10000
  } port_state_t;

endpackage

//--- hdl/gport_target.sv
// Hub-side graphics port arbiter, target select and lane control
// Functional notes
// - Target select asserted when claiming frame access
// - Target select unused in pipelined or sideband
// - Grant hands bus or signals queued data
// - Three-bit status encodes each grant purpose
// - Lanes carry address and all data
// - Frame single rate; data phases channel rate
// - Command in address, byte enables in data
// - Byte enables ignored for graphics read data
// - Command lanes follow address lane rate
// - Parity only in frame transactions
// - No parity in fast writes; pulled high
// - Inversion flag one means invert low half
// - Inversion only in 3.0 signalling mode
// - Flag sampled with upper strobe pair
// - Port logic reset from hub reset input
// - Bus locking unsupported on this port
// - Conventional cycles follow revision 2.1 behaviour
// - Frame marks frame accesses, idle otherwise
// - First strobe odd items, second even
`timescale 1ns/1ps
`default_nettype none
module gport_target
  import gport_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic mode_30,
  input wire logic [1:0] channel_rate,
  input wire logic port_bus_request_n,
  input wire logic port_frame_n,
  input wire logic pipelined_request_strobe_n,
  input wire logic [AD_W-1:0] port_addr_data_lanes_in,
  input wire logic [CBE_W-1:0] port_cmd_byte_enable_in,
  input wire logic port_parity_in,
  input wire logic dbi_lo_in,
  input wire logic upper_first_data_strobe,
  input wire logic upper_second_data_strobe,
  input wire logic queued_data_ready,
  input wire logic [2:0] queued_data_purpose,
  input wire logic [AD_W-1:0] read_data,
  output logic port_bus_grant_n,
  output logic [GST_W-1:0] grant_purpose_status,
  output logic port_target_select_n,
  output logic port_target_select_oe_n,
  output logic [AD_W-1:0] port_addr_data_lanes_out,
  output logic port_addr_data_lanes_oe_n,
  output logic port_parity_out,
  output logic port_parity_oe_n,
  output logic parity_error,
  output logic [AD_W-1:0] captured_addr,
  output logic [CBE_W-1:0] captured_cmd,
  output logic [CBE_W-1:0] captured_be,
  output logic [LO_HALF_W-1:0] lo_half_word,
  output logic [1:0] active_rate,
  output logic queued_data_taken
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [4:0] ctl_sync;
  logic [AD_W-1:0] ad_sync;
  logic [CBE_W-1:0] cbe_sync;
  logic mode_30_sync;

  level_sync #(.WIDTH(5)) u_ctl_sync (
    .clk(core_clk),
    .rst_n(resetn),
    .async_in({port_bus_request_n, port_frame_n, pipelined_request_strobe_n, port_parity_in, mode_30}),
    .sync_out(ctl_sync)
  );
  level_sync #(.WIDTH(AD_W)) u_ad_sync (
    .clk(core_clk),
    .rst_n(resetn),
    .async_in(port_addr_data_lanes_in),
    .sync_out(ad_sync)
  );
  level_sync #(.WIDTH(CBE_W)) u_cbe_sync (
    .clk(core_clk),
    .rst_n(resetn),
    .async_in(port_cmd_byte_enable_in),
    .sync_out(cbe_sync)
  );

  wire req_act = ~ctl_sync[4];
  wire frame_act = ~ctl_sync[3];
  wire pipe_act = ~ctl_sync[2];
  wire par_in_s = ctl_sync[1];
  assign mode_30_sync = ctl_sync[0];

  // ---------------------------------------------------------------
  // Link-domain reset and low-half capture
  // ---------------------------------------------------------------
  logic [1:0] link_rst_reg;
  logic mode_link;
  logic [LO_HALF_W-1:0] lo_word_link;
  logic lo_toggle_link;

  always_ff @(posedge link_clk)
  begin
    link_rst_reg <= {link_rst_reg[0], resetn};
  end

  level_sync #(.WIDTH(1)) u_mode_link (
    .clk(link_clk),
    .rst_n(link_rst_reg[1]),
    .async_in(mode_30),
    .sync_out(mode_link)
  );

  dbi_capture u_dbi (
    .strobe_clk(link_clk),
    .link_rst_n(link_rst_reg[1]),
    .mode_30(mode_link),
    .upper_first_data_strobe(upper_first_data_strobe),
    .upper_second_data_strobe(upper_second_data_strobe),
    .lo_lanes(port_addr_data_lanes_in[LO_HALF_W-1:0]),
    .dbi_lo(dbi_lo_in),
    .word_reg(lo_word_link),
    .word_toggle_reg(lo_toggle_link)
  );

  // Toggle crossing; word is stable once toggle is seen
  logic [2:0] tog_sync_reg;
  logic [LO_HALF_W-1:0] lo_word_hold;
  wire lo_new = tog_sync_reg[2] ^ tog_sync_reg[1];

  // ---------------------------------------------------------------
  // Port state machine
  // ---------------------------------------------------------------
  port_state_t state_reg, state_next;
  logic [2:0] beat_reg;
  wire beats_done = beat_reg == 3'(DATA_BEATS - 1);
  wire start_frame = frame_act;
  wire start_pipe = pipe_act & ~frame_act;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (req_act)
          state_next = ST_GRANT;
        else if (queued_data_ready)
          state_next = ST_DATA;
      ST_GRANT:
        if (start_frame)
          state_next = ST_FRAME;
        else if (start_pipe)
          state_next = ST_PIPE;
      ST_FRAME:
        if (!frame_act)
          state_next = ST_IDLE;
      ST_PIPE:
        if (!pipe_act)
          state_next = ST_IDLE;
      ST_DATA:
        if (beats_done)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // Grant decode
  wire grant_next = (state_next == ST_GRANT) | (state_reg == ST_IDLE && state_next == ST_DATA);
  wire [2:0] gst_next = (state_next == ST_DATA) ? queued_data_purpose : GST_START_REQ;
  wire in_frame = state_reg == ST_FRAME;
  wire in_data = state_reg == ST_DATA;
  wire data_is_read = (queued_data_purpose == GST_LP_READ) | (queued_data_purpose == GST_HP_READ);
  logic gst_reg_is_fw;
  assign gst_reg_is_fw = grant_purpose_status == GST_FAST_WRITE;
  wire fast_write = gst_reg_is_fw;

  // Rate: frame cycles are 1X, data phases use channel rate
  wire [1:0] rate_next = (state_next == ST_DATA) ? channel_rate : RATE_1X;

  // Address and command capture on first frame/pipe cycle
  wire addr_phase = (state_reg == ST_GRANT) & (start_frame | start_pipe);
  wire be_phase = (in_frame | in_data) & ~(in_data & data_is_read);

  // Parity over previous frame cycle
  logic par_calc_reg;
  logic par_check_reg;
  wire par_calc = ^{ad_sync, cbe_sync};

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state_reg <= ST_IDLE;
      beat_reg <= 3'h0;
      port_bus_grant_n <= 1'b1;
      grant_purpose_status <= GST_RST;
      port_target_select_n <= 1'b1;
      port_target_select_oe_n <= 1'b1;
      port_addr_data_lanes_out <= AD_RST;
      port_addr_data_lanes_oe_n <= 1'b1;
      port_parity_out <= 1'b1;
      port_parity_oe_n <= 1'b1;
      parity_error <= 1'b0;
      captured_addr <= AD_RST;
      captured_cmd <= 4'h0;
      captured_be <= 4'h0;
      lo_half_word <= 16'h0000;
      active_rate <= RATE_1X;
      queued_data_taken <= 1'b0;
      par_calc_reg <= 1'b0;
      par_check_reg <= 1'b0;
      tog_sync_reg <= 3'h0;
      lo_word_hold <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      beat_reg <= (state_reg == ST_DATA) ? beat_reg + 3'h1 : 3'h0;
      port_bus_grant_n <= ~grant_next;
      if (grant_next)
        grant_purpose_status <= gst_next;
      port_target_select_n <= ~(state_next == ST_FRAME);
      port_target_select_oe_n <= ~(state_next == ST_FRAME);
      port_addr_data_lanes_out <= read_data;
      port_addr_data_lanes_oe_n <= ~(state_next == ST_DATA && data_is_read);
      port_parity_out <= in_frame ? par_calc : 1'b1;
      port_parity_oe_n <= 1'b1;
      par_calc_reg <= par_calc;
      par_check_reg <= in_frame & ~fast_write;
      parity_error <= par_check_reg & (par_in_s != par_calc_reg) & in_frame;
      if (addr_phase)
      begin
        captured_addr <= ad_sync;
        captured_cmd <= cbe_sync;
      end
      if (be_phase)
        captured_be <= cbe_sync;
      active_rate <= rate_next;
      queued_data_taken <= state_reg == ST_IDLE && state_next == ST_DATA;
      tog_sync_reg <= {tog_sync_reg[1:0], lo_toggle_link};
      lo_word_hold <= lo_word_link;
      if (lo_new && mode_30_sync)
        lo_half_word <= lo_word_hold;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_select_frame: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == ST_FRAME |-> !port_target_select_n)
    else $error("target select missing in frame access");
  chk_select_pipe: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == ST_PIPE || state_reg == ST_DATA |-> port_target_select_n)
    else $error("target select driven outside frame access");
  chk_grant_req: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == ST_IDLE && req_act |=> !port_bus_grant_n && grant_purpose_status == GST_START_REQ)
    else $error("request not granted");
  chk_grant_purpose: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == ST_IDLE && !req_act && queued_data_ready
    |=> !port_bus_grant_n && grant_purpose_status == $past(queued_data_purpose))
    else $error("grant purpose wrong");
  chk_rate_frame: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == ST_FRAME |-> active_rate == RATE_1X)
    else $error("frame cycle not single rate");
  chk_rate_data: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(state_reg == ST_DATA) |-> active_rate == $past(channel_rate))
    else $error("data phase rate mismatch");
  chk_parity_idle: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg != ST_FRAME |=> !parity_error[*2])
    else $error("parity checked outside frame");
  chk_parity_float: assert property (@(posedge core_clk) disable iff (!resetn)
    port_parity_oe_n)
    else $error("parity driven by hub");
  chk_read_be: assert property (@(posedge core_clk) disable iff (!resetn)
    in_data && data_is_read |=> $stable(captured_be))
    else $error("byte enables used for read data");
  chk_data_len: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(state_reg == ST_DATA) |-> ##4 state_reg == ST_IDLE)
    else $error("data phase length wrong");

endmodule // gport_target
`default_nettype wire

//--- hdl/level_sync.sv
// Two-flop synchroniser for a group of levels
`timescale 1ns/1ps
`default_nettype none
module level_sync
  import gport_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // level_sync
`default_nettype wire
